// *** core/ppc_top.sv ***
// port pad configuration: AXI4-Lite registers and per-pin pad control
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module ppc_top
   import ppc_pkg::*;
#(
   parameter int ADDR_W    = 12,
   parameter int COM_GROUP = GRP_B
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [ADDR_W-1:0]          awaddr,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   input  wire logic [ADDR_W-1:0]          araddr,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   input  wire logic [NGRP-1:0][7:0]       pad_in,
   output ppc_pad_t [NGRP-1:0]             pad_o,
   input  wire logic [7:0]                 scan_out,
   output logic [7:0]                      com_func,
   output logic [7:0]                      seg_func,
   output logic [7:0]                      high_cur,
   output logic [7:0]                      display_ctrl
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (ADDR_W < 12) begin : g_bad_addr
      $error("ADDR_W must be at least 12");
   end
   if (COM_GROUP < 0 || COM_GROUP >= NGRP) begin : g_bad_grp
      $error("COM_GROUP out of range");
   end

   // ****************************************************************
   // address decode
   // ****************************************************************
   function automatic ppc_dec_t decode(input logic [ADDR_W-1:0] a);
      ppc_dec_t   d;
      logic [9:0] i;
      d.kind = REG_NONE;
      d.grp  = 3'h0;
      i      = a[11:2];
      if (a[1:0] != 2'h0 || (a >> 12) != '0) begin
         d.kind = REG_NONE;
      end else if (i == IDX_SEL) begin
         d.kind = REG_SEL;
      end else if (i == IDX_OD) begin
         d.kind = REG_OD;
      end else if (i == IDX_DP) begin
         d.kind = REG_DP;
      end else if (i == IDX_OPT) begin
         d.kind = REG_OPT;
      end else begin
         for (int k = 0; k < NGRP; k++) begin
            if (i == PU_IDX[k]) begin
               d.kind = REG_PU;
               d.grp  = 3'(k);
            end else if (i == DATA_IDX[k]) begin
               d.kind = REG_DATA;
               d.grp  = 3'(k);
            end else if (i == DIR_IDX[k]) begin
               d.kind = REG_DIR;
               d.grp  = 3'(k);
            end
         end
      end
      return d;
   endfunction : decode

   // ****************************************************************
   // write channel
   // ****************************************************************
   logic                 aw_full_q;
   logic [ADDR_W-1:0]    awaddr_q;
   logic                 w_full_q;
   logic [31:0]          wdata_q;
   logic [3:0]           wstrb_q;
   logic                 bvalid_q;
   logic [1:0]           bresp_q;
   logic                 aw_hs;
   logic                 w_hs;
   logic                 wr_go;
   logic                 wr_en;
   logic [ADDR_W-1:0]    wr_addr;
   logic [31:0]          wr_dat;
   logic [3:0]           wr_strb;
   ppc_dec_t             wr_dec;
   assign awready = !aw_full_q && !bvalid_q;
   assign wready  = !w_full_q && !bvalid_q;
   assign aw_hs   = awvalid && awready;
   assign w_hs    = wvalid && wready;
   assign wr_go   = (aw_full_q || aw_hs) && (w_full_q || w_hs);
   assign wr_addr = aw_full_q ? awaddr_q : awaddr;
   assign wr_dat  = w_full_q ? wdata_q : wdata;
   assign wr_strb = w_full_q ? wstrb_q : wstrb;
   assign wr_dec  = decode(wr_addr);
   assign wr_en   = wr_go && wr_dec.kind != REG_NONE && wr_strb[0];
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
      end else begin
         aw_full_q <= (aw_full_q || aw_hs) && !wr_go;
         w_full_q  <= (w_full_q || w_hs) && !wr_go;
         if (aw_hs) begin
            awaddr_q <= awaddr;
         end
         if (w_hs) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wr_dec.kind == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   logic [NGRP-1:0][7:0] pu_q;
   logic [NGRP-1:0][7:0] data_q;
   logic [NGRP-1:0][7:0] dir_q;
   logic [7:0]           sel_q;
   logic [7:0]           od_q;
   logic [7:0]           dp_q;
   logic [7:0]           opt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pu_q <= PU_RST;
      end else if (wr_en && wr_dec.kind == REG_PU) begin
         pu_q[wr_dec.grp] <= wr_dat[7:0] & GRP_MASK[wr_dec.grp];
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= DATA_RST;
      end else if (wr_en && wr_dec.kind == REG_DATA) begin
         data_q[wr_dec.grp] <= wr_dat[7:0] & GRP_MASK[wr_dec.grp];
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_q <= DIR_RST;
      end else if (wr_en && wr_dec.kind == REG_DIR) begin
         dir_q[wr_dec.grp] <= wr_dat[7:0] & GRP_MASK[wr_dec.grp];
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= 8'h00;
         dp_q  <= 8'h00;
         opt_q <= 8'h00;
      end else if (wr_en) begin
         if (wr_dec.kind == REG_SEL) begin
            sel_q <= wr_dat[7:0];
         end
         if (wr_dec.kind == REG_DP) begin
            dp_q <= wr_dat[7:0] & DP_MASK;
         end
         if (wr_dec.kind == REG_OPT) begin
            opt_q <= wr_dat[7:0] & OPT_MASK;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         od_q <= 8'h00;
      end else if (wr_en && wr_dec.kind == REG_OD) begin
         od_q <= wr_dat[7:0] & OD_MASK;
      end
   end

   // ****************************************************************
   // read channel
   // ****************************************************************
   logic        rvalid_q;
   logic [7:0]  rdata_q;
   logic [1:0]  rresp_q;
   logic        ar_hs;
   logic [7:0]  rd_val;
   ppc_dec_t    rd_dec;
   assign arready = !rvalid_q;
   assign ar_hs   = arvalid && arready;
   assign rd_dec  = decode(araddr);
   assign rvalid  = rvalid_q;
   assign rresp   = rresp_q;
   assign rdata   = {24'h0, rdata_q};
   always_comb begin
      rd_val = 8'h00;
      case (rd_dec.kind)
         REG_PU:   rd_val = pu_q[rd_dec.grp];
         REG_DATA: rd_val = ((dir_q[rd_dec.grp] & pad_in[rd_dec.grp]) |
                             (~dir_q[rd_dec.grp] & data_q[rd_dec.grp]))
                            & GRP_MASK[rd_dec.grp];
         REG_DIR:  rd_val = dir_q[rd_dec.grp];
         REG_SEL:  rd_val = sel_q;
         REG_OD:   rd_val = od_q;
         REG_DP:   rd_val = dp_q;
         REG_OPT:  rd_val = opt_q;
         default:  rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 8'h00;
         rresp_q  <= RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_val;
         rresp_q  <= (rd_dec.kind == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // common-line function selection
   // ****************************************************************
   logic       lock;
   logic [7:0] com_d;
   logic [7:0] seg_d;
   logic [7:0] hc_d;
   assign lock = dp_q[HC_LOCK_BIT];
   always_comb begin
      com_d = 8'h00;
      seg_d = 8'h00;
      hc_d  = 8'h00;
      if (lock) begin
         hc_d = sel_q;
      end else if (dp_q[DISP_TYPE_BIT]) begin
         if (opt_q[OPT_4X4_BIT]) begin
            com_d = sel_q & MAT_COM_MASK;
            seg_d = sel_q & MAT_SEG_MASK;
         end else begin
            com_d = sel_q;
         end
      end else begin
         com_d = sel_q;
      end
   end

   // ****************************************************************
   // per-pin pad drive
   // ****************************************************************
   wire ppc_pad_t [NGRP-1:0] pad_d;
   ppc_pad_t [NGRP-1:0]      pad_q;
   for (genvar g = 0; g < NGRP; g++) begin : g_grp
      for (genvar b = 0; b < 8; b++) begin : g_pin
         localparam int OD_BIT = (g == GRP_C && b == 2) ? 0 :
                                 (g == GRP_C && b == 3) ? 1 :
                                 (g == GRP_E && b == 2) ? 2 :
                                 (g == GRP_E && b == 3) ? 3 : -1;
         wire disp_pin;
         wire od_pin;
         if (OD_BIT >= 0) begin : g_od
            assign od_pin = od_q[OD_BIT];
         end else begin : g_pp
            assign od_pin = 1'b0;
         end
         if (g == COM_GROUP) begin : g_com
            assign disp_pin = com_d[b] | seg_d[b];
         end else begin : g_gpio
            assign disp_pin = 1'b0;
         end
         assign pad_d[g].out[b]     = disp_pin ? scan_out[b] : data_q[g][b] & !od_pin;
         assign pad_d[g].oe_n[b]    = disp_pin ? 1'b0 :
                                      dir_q[g][b] | (od_pin & data_q[g][b]) |
                                      !GRP_MASK[g][b];
         assign pad_d[g].pull_en[b] = pu_q[g][b];
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_q <= {NGRP{PAD_IDLE}};
      end else begin
         pad_q <= pad_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         com_func     <= 8'h00;
         seg_func     <= 8'h00;
         high_cur     <= 8'h00;
         display_ctrl <= 8'h00;
      end else begin
         com_func     <= com_d;
         seg_func     <= seg_d;
         high_cur     <= hc_d;
         display_ctrl <= dp_q;
      end
   end
   assign pad_o = pad_q;

   // ****************************************************************
   // assertions
   // ****************************************************************
   pu_follow_a: assert property (
      wr_en && wr_dec.kind == REG_PU && wr_dec.grp == 3'(GRP_B)
      |-> ##2 pad_o[GRP_B].pull_en == $past(wr_dat[7:0], 2))
      else $error("pull-up enable does not follow write");
   narrow_pu_a: assert property (
      pad_o[GRP_A].pull_en[7:4] == 4'h0 && pad_o[GRP_G].pull_en[7:4] == 4'h0)
      else $error("upper pull-up bits set in four-pin group");
   lock_hc_a: assert property (
      lock |=> high_cur == $past(sel_q) && com_func == 8'h00 && seg_func == 8'h00)
      else $error("locked pins not in high-current mode");
   unlock_hc_a: assert property (
      !lock |=> high_cur == 8'h00)
      else $error("high-current drive while unlocked");
   lock_gpio_a: assert property (
      lock && od_q == 8'h00 ##1 lock && od_q == 8'h00
      |-> pad_o[COM_GROUP].oe_n == ($past(dir_q[COM_GROUP]) | ~GRP_MASK[COM_GROUP]))
      else $error("scan logic drives locked pins");
   plain_com_a: assert property (
      !lock && dp_q[DISP_TYPE_BIT] && !opt_q[OPT_4X4_BIT]
      |=> com_func == $past(sel_q) && seg_func == 8'h00)
      else $error("matrix common select wrong");
   mat4_a: assert property (
      !lock && dp_q[DISP_TYPE_BIT] && opt_q[OPT_4X4_BIT]
      |=> com_func[7:4] == 4'h0 && seg_func[3:0] == 4'h0 &&
          (com_func | seg_func) == $past(sel_q))
      else $error("4x4 common and segment split wrong");
   od_drive_a: assert property (
      od_q[1] && !dir_q[GRP_C][3] && data_q[GRP_C][3] |=> pad_o[GRP_C].oe_n[3])
      else $error("open-drain pin drives high");
   dir_in_a: assert property (
      dir_q[GRP_A][0] |=> pad_o[GRP_A].oe_n[0])
      else $error("input pin is driven");
   rd_live_a: assert property (
      ar_hs && rd_dec.kind == REG_DATA && rd_dec.grp == 3'(GRP_B) && dir_q[GRP_B] == 8'hff
      |=> rvalid && rdata[7:0] == $past(pad_in[GRP_B]))
      else $error("data read does not show pin level");
   wr_resp_a: assert property (
      wr_go |=> bvalid)
      else $error("write response missing");
endmodule : ppc_top
`default_nettype wire

// *** core/ppc_pkg.sv ***
// constants and types for the port pad configuration block
`default_nettype none
package ppc_pkg;
   // ****************************************************************
   // groups and register indices (byte address is four times index)
   // ****************************************************************
   localparam int NGRP  = 7;
   localparam int GRP_A = 0;
   localparam int GRP_B = 1;
   localparam int GRP_C = 2;
   localparam int GRP_E = 3;
   localparam int GRP_G = 5;
   localparam logic [NGRP-1:0][9:0] PU_IDX   = {10'h01e, 10'h01d, 10'h01c, 10'h01b,
                                                10'h019, 10'h018, 10'h017};
   localparam logic [NGRP-1:0][9:0] DATA_IDX = {10'h0d8, 10'h0c8, 10'h0c0, 10'h0b0,
                                                10'h090, 10'h080, 10'h0f8};
   localparam logic [NGRP-1:0][9:0] DIR_IDX  = {10'h0f7, 10'h0f2, 10'h0ef, 10'h0ee,
                                                10'h0ec, 10'h0eb, 10'h0ea};
   localparam logic [9:0] IDX_SEL = 10'h023;
   localparam logic [9:0] IDX_OD  = 10'h025;
   localparam logic [9:0] IDX_DP  = 10'h0b1;
   localparam logic [9:0] IDX_OPT = 10'h026;
   // ****************************************************************
   // field layouts and reset values
   // ****************************************************************
   localparam logic [NGRP-1:0][7:0] GRP_MASK = {8'hff, 8'h0f, 8'hff, 8'hff,
                                                8'hff, 8'hff, 8'h0f};
   localparam logic [NGRP-1:0][7:0] PU_RST   = '0;
   localparam logic [NGRP-1:0][7:0] DATA_RST = GRP_MASK;
   localparam logic [NGRP-1:0][7:0] DIR_RST  = GRP_MASK;
   localparam logic [7:0] OD_MASK      = 8'h0f;
   localparam logic [7:0] DP_MASK      = 8'h7f;
   localparam logic [7:0] OPT_MASK     = 8'h01;
   localparam logic [7:0] MAT_COM_MASK = 8'h0f;
   localparam logic [7:0] MAT_SEG_MASK = 8'hf0;
   localparam int HC_LOCK_BIT   = 0;
   localparam int DISP_TYPE_BIT = 2;
   localparam int OPT_4X4_BIT   = 0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum {
      REG_NONE, REG_PU, REG_DATA, REG_DIR, REG_SEL, REG_OD, REG_DP, REG_OPT
   } ppc_reg_t;
   typedef struct packed {
      ppc_reg_t   kind;
      logic [2:0] grp;
   } ppc_dec_t;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] pull_en;
   } ppc_pad_t;
   localparam ppc_pad_t PAD_IDLE = '{out: 8'h00, oe_n: 8'hff, pull_en: 8'h00};
endpackage : ppc_pkg
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking testbench for the port pad configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import ppc_pkg::*;
;
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic [11:0]           awaddr = '0, araddr = '0;
   logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                  arvalid = 1'b0, rready = 1'b0;
   logic [31:0]           wdata = '0;
   logic [3:0]            wstrb = '0;
   logic [NGRP-1:0][7:0]  pad_in = '0;
   logic [7:0]            scan_out = '0;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [1:0]            bresp, rresp;
   logic [31:0]           rdata;
   ppc_pad_t [NGRP-1:0]   pad_o;
   logic [7:0]            com_func, seg_func, high_cur, display_ctrl;
   int                    fail_count = 0;
   int                    comparisons = 0;

   always #4 clk = ~clk;

   ppc_top dut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .pad_in(pad_in), .pad_o(pad_o), .scan_out(scan_out), .com_func(com_func),
      .seg_func(seg_func), .high_cur(high_cur), .display_ctrl(display_ctrl));

   // ****************************************************************
   // reporting
   // ****************************************************************
   task automatic final_report;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic hang(input string name);
      fail_count++;
      $display("MISMATCH %s expected handshake seen timeout", name);
      final_report();
   endtask : hang

   // ****************************************************************
   // bus master
   // ****************************************************************
   task automatic axi_write(input logic [9:0] idx, input logic [7:0] val,
                            input logic [3:0] strb, input logic [1:0] exp_resp);
      int   n;
      logic aw_done, w_done, aw_ok, w_ok, got;
      logic [1:0] resp;
      aw_done = 1'b0;
      w_done = 1'b0;
      got = 1'b0;
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, val};
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50 && !(aw_done && w_done); n++) begin
         @(negedge clk);
         aw_ok = !aw_done && awready;
         w_ok = !w_done && wready;
         @(posedge clk);
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
         aw_done = aw_done | aw_ok;
         w_done = w_done | w_ok;
      end
      if (!(aw_done && w_done)) hang("write address/data");
      for (n = 0; n < 50 && !got; n++) begin
         @(negedge clk);
         got = bvalid;
         resp = bresp;
         @(posedge clk);
      end
      if (!got) hang("write response");
      bready <= 1'b0;
      chk("bresp", {30'h0, exp_resp}, {30'h0, resp});
   endtask : axi_write

   task automatic axi_read(input logic [9:0] idx, input logic [7:0] exp,
                           input logic [1:0] exp_resp);
      int   n;
      logic ok, got;
      logic [31:0] data;
      logic [1:0]  resp;
      ok = 1'b0;
      got = 1'b0;
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50 && !ok; n++) begin
         @(negedge clk);
         ok = arready;
         @(posedge clk);
      end
      if (!ok) hang("read address");
      arvalid <= 1'b0;
      for (n = 0; n < 50 && !got; n++) begin
         @(negedge clk);
         got = rvalid;
         data = rdata;
         resp = rresp;
         @(posedge clk);
      end
      if (!got) hang("read data");
      rready <= 1'b0;
      chk("rresp", {30'h0, exp_resp}, {30'h0, resp});
      chk("rdata", {24'h0, exp}, data);
   endtask : axi_read

   task automatic wr(input logic [9:0] idx, input logic [7:0] val);
      axi_write(idx, val, 4'h1, RESP_OKAY);
   endtask : wr

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      for (int g = 0; g < NGRP; g++) begin
         axi_read(PU_IDX[g], 8'h00, RESP_OKAY);
         axi_read(DIR_IDX[g], GRP_MASK[g], RESP_OKAY);
         chk("oe_n after reset", 32'hff, {24'h0, pad_o[g].oe_n});
      end
      axi_read(IDX_SEL, 8'h00, RESP_OKAY);
      axi_read(IDX_OD, 8'h00, RESP_OKAY);
      axi_read(IDX_DP, 8'h00, RESP_OKAY);
      pad_in[GRP_B] <= 8'h96;
      axi_read(DATA_IDX[GRP_B], 8'h96, RESP_OKAY);
   endtask : t_reset

   task automatic t_pullup;
      for (int g = 0; g < NGRP; g++) begin
         wr(PU_IDX[g], 8'hff);
         axi_read(PU_IDX[g], GRP_MASK[g], RESP_OKAY);
         @(negedge clk);
         chk("pull_en", {24'h0, GRP_MASK[g]}, {24'h0, pad_o[g].pull_en});
      end
      axi_write(PU_IDX[GRP_B], 8'h5a, 4'h0, RESP_OKAY);
      axi_read(PU_IDX[GRP_B], 8'hff, RESP_OKAY);
      wr(PU_IDX[GRP_B], 8'h00);
      @(negedge clk);
      chk("pull_en off", 32'h0, {24'h0, pad_o[GRP_B].pull_en});
   endtask : t_pullup

   task automatic t_dir_data;
      @(posedge clk);
      pad_in[GRP_C] <= 8'h3c;
      wr(DATA_IDX[GRP_C], 8'ha5);
      wr(DIR_IDX[GRP_C], 8'h00);
      @(negedge clk);
      chk("out", 32'ha5, {24'h0, pad_o[GRP_C].out});
      chk("oe_n", 32'h00, {24'h0, pad_o[GRP_C].oe_n});
      axi_read(DATA_IDX[GRP_C], 8'ha5, RESP_OKAY);
      wr(DIR_IDX[GRP_C], 8'hf0);
      axi_read(DATA_IDX[GRP_C], 8'h35, RESP_OKAY);
      wr(DIR_IDX[GRP_A], 8'h00);
      wr(DATA_IDX[GRP_A], 8'hff);
      axi_read(DATA_IDX[GRP_A], 8'h0f, RESP_OKAY);
   endtask : t_dir_data

   task automatic t_open_drain;
      logic [7:0] od, cm, em;
      wr(DIR_IDX[GRP_C], 8'h00);
      wr(DATA_IDX[GRP_C], 8'hff);
      wr(DIR_IDX[GRP_E], 8'h00);
      wr(DATA_IDX[GRP_E], 8'hff);
      for (int i = 0; i < 2; i++) begin
         od = (i == 0) ? 8'h06 : 8'h09;
         cm = {4'h0, od[1:0], 2'b00};
         em = {4'h0, od[3:2], 2'b00};
         wr(IDX_OD, od);
         @(negedge clk);
         chk("od out c", {24'h0, ~cm}, {24'h0, pad_o[GRP_C].out});
         chk("od oe_n c", {24'h0, cm}, {24'h0, pad_o[GRP_C].oe_n});
         chk("od out e", {24'h0, ~em}, {24'h0, pad_o[GRP_E].out});
         chk("od oe_n e", {24'h0, em}, {24'h0, pad_o[GRP_E].oe_n});
      end
      wr(IDX_OD, 8'hff);
      axi_read(IDX_OD, OD_MASK, RESP_OKAY);
      wr(IDX_OD, 8'h00);
      @(negedge clk);
      chk("push-pull oe_n c", 32'h00, {24'h0, pad_o[GRP_C].oe_n});
      chk("push-pull out e", 32'hff, {24'h0, pad_o[GRP_E].out});
   endtask : t_open_drain

   task automatic t_display;
      scan_out <= 8'h3c;
      wr(IDX_DP, 8'h04);
      wr(IDX_SEL, 8'ha5);
      @(negedge clk);
      chk("com_func", 32'ha5, {24'h0, com_func});
      chk("seg_func", 32'h00, {24'h0, seg_func});
      chk("high_cur", 32'h00, {24'h0, high_cur});
      chk("display_ctrl", 32'h04, {24'h0, display_ctrl});
      chk("scan out", 32'h7e, {24'h0, pad_o[GRP_B].out});
      chk("scan oe_n", 32'h5a, {24'h0, pad_o[GRP_B].oe_n});
      wr(IDX_OPT, 8'hff);
      axi_read(IDX_OPT, OPT_MASK, RESP_OKAY);
      @(negedge clk);
      chk("com 4x4", 32'h05, {24'h0, com_func});
      chk("seg 4x4", 32'ha0, {24'h0, seg_func});
      wr(IDX_OPT, 8'h00);
   endtask : t_display

   task automatic t_lock;
      wr(IDX_DP, 8'h05);
      @(negedge clk);
      chk("lock com", 32'h00, {24'h0, com_func});
      chk("lock seg", 32'h00, {24'h0, seg_func});
      chk("lock high_cur", 32'ha5, {24'h0, high_cur});
      chk("lock oe_n", 32'hff, {24'h0, pad_o[GRP_B].oe_n});
      wr(DIR_IDX[GRP_B], 8'h00);
      wr(DATA_IDX[GRP_B], 8'h5a);
      @(negedge clk);
      chk("lock out", 32'h5a, {24'h0, pad_o[GRP_B].out});
      chk("lock drive", 32'h00, {24'h0, pad_o[GRP_B].oe_n});
      wr(IDX_SEL, 8'h00);
      @(negedge clk);
      chk("high_cur off", 32'h00, {24'h0, high_cur});
      wr(IDX_DP, 8'hff);
      axi_read(IDX_DP, DP_MASK, RESP_OKAY);
      wr(IDX_DP, 8'h00);
      wr(IDX_SEL, 8'h0f);
      @(negedge clk);
      chk("unlock com", 32'h0f, {24'h0, com_func});
      chk("unlock high_cur", 32'h00, {24'h0, high_cur});
   endtask : t_lock

   task automatic t_unmapped;
      axi_write(10'h030, 8'h55, 4'h1, RESP_SLVERR);
      axi_read(10'h030, 8'h00, RESP_SLVERR);
   endtask : t_unmapped

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_pullup();
      t_dir_data();
      t_open_drain();
      t_display();
      t_lock();
      t_unmapped();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
